// file: hdl/imacfg_pkg.sv
`default_nettype none
// ============================================================
// Shared constants and carriers of the miscellaneous
// configuration and diagnostic register set.
// ============================================================
package imacfg_pkg;

    // ========================================================
    // Register indices; the APB byte address is four times these.
    // ========================================================
    localparam logic [11:0] IDX_MISC_CONTROL     = 12'h404;
    localparam logic [11:0] IDX_MEM_TEST_ADDR_LO = 12'h405;
    localparam logic [11:0] IDX_MEM_TEST_ADDR_MI = 12'h406;
    localparam logic [11:0] IDX_MEM_TEST_CONTROL = 12'h407;
    localparam logic [11:0] IDX_MEM_TEST_DATA    = 12'h408;
    localparam logic [11:0] IDX_LINK_DIAG_SELECT = 12'h409;
    localparam logic [11:0] IDX_LINK_DELAY_SNAP  = 12'h40A;

    // ========================================================
    // Field positions.
    // ========================================================
    localparam int MISC_ALT_GROUP_BIT = 6;
    localparam int MISC_PHY_SIZE_LSB  = 4;
    localparam int MISC_EXT_HEC_BIT   = 3;
    localparam int MISC_ADDR_CHK_LSB  = 0;
    localparam int TCTL_ADDR20_BIT    = 7;
    localparam int TCTL_MODE_LSB      = 4;
    localparam int TCTL_ADDR_HI_LSB   = 0;
    localparam int DIAG_WCNT_MSB_BIT  = 5;
    localparam int DIAG_LINK_LSB      = 0;

    // ========================================================
    // Writable masks; reserved bits are stored as zero.
    // ========================================================
    localparam logic [7:0] MISC_WRITE_MASK = 8'h7F;
    localparam logic [7:0] DIAG_WRITE_MASK = 8'h1F;

    // ========================================================
    // Reset values.
    // ========================================================
    localparam logic [7:0] RST_MISC_CONTROL = 8'h00;
    localparam logic [7:0] RST_ADDR_BYTE    = 8'h00;
    localparam logic [7:0] RST_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_TEST_DATA    = 8'h00;
    localparam logic [7:0] RST_DIAG_SELECT  = 8'h00;
    localparam logic [8:0] RST_SNAPSHOT     = 9'h000;

    // ========================================================
    // Encodings.
    // ========================================================
    localparam logic [1:0] PHY_PER_4     = 2'h0;
    localparam logic [1:0] PHY_PER_16    = 2'h1;
    localparam logic [1:0] PHY_SHARED    = 2'h2;
    localparam logic [1:0] PHY_PER_8     = 2'h3;
    localparam logic [2:0] TEST_NORMAL   = 3'h0;
    localparam logic [2:0] TEST_SRAM     = 3'h1;
    localparam logic [2:0] WIN_HALF      = 3'h0;
    localparam logic [2:0] WIN_QUARTER   = 3'h4;

    // Request to the differential-delay SRAM during test access.
    typedef struct packed {
        logic        req;
        logic        we;
        logic [20:0] addr;
        logic [7:0]  wdata;
    } imacfg_sram_req_s;

endpackage
`default_nettype wire

// file: hdl/imacfg_sram_tester.sv
`default_nettype none
// ============================================================
// Single-byte access engine towards the differential-delay SRAM.
// ============================================================
module imacfg_sram_tester (
    input  wire logic                       pclk,       // Clock.
    input  wire logic                       presetn,    // Asynchronous reset, active low.
    input  wire logic                       start,      // Pulse that launches one access.
    input  wire logic                       we,         // One for a write, zero for a read.
    input  wire logic [20:0]                addr,       // Test address.
    input  wire logic [7:0]                 wdata,      // Byte to write.
    output imacfg_pkg::imacfg_sram_req_s    sram_out,   // Request held until acknowledged.
    input  wire logic                       sram_ack,   // SRAM has completed the access.
    input  wire logic [7:0]                 sram_rdata, // Read byte, valid with sram_ack.
    output logic                            done,       // One-cycle pulse after the ack.
    output logic [7:0]                      rdata       // Last byte read.
);

    typedef enum logic {ST_IDLE, ST_WAIT} imacfg_st_e;

    imacfg_st_e state_r;

    // ========================================================
    // Access sequencing.
    // ========================================================
    // Holds the request until the SRAM acknowledges, then reports done.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= ST_IDLE;
            sram_out <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        sram_out.req   <= 1'b1;
                        sram_out.we    <= we;
                        sram_out.addr  <= addr;
                        sram_out.wdata <= wdata;
                        state_r        <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (sram_ack) begin
                        sram_out.req <= 1'b0;
                        done         <= 1'b1;
                        state_r      <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Captures the read byte as the access completes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 8'h00;
        end else if (state_r == ST_WAIT && sram_ack && !sram_out.we) begin
            rdata <= sram_rdata;
        end
    end

endmodule
`default_nettype wire

// file: hdl/imacfg_regs.sv
// Behaviour
// - Group down with alternate bit 6 set: tx cell-available as if links active, else inactive.
// - PHY size bits 5-4 pick sharing: per 4, per 16, all shared, per 8 addresses.
// - Bit 3 set: HEC byte bit 7 is the error flag; clear: internal checker.
// - Bits 2, 1, 0 enable comparing address bits 4, 3, 2 on tx and rx buses.
// - Test address is 21 bits: low byte, middle byte, control nibble, control bit 7.
// - Test access field bits 6-4: 0 normal, 1 SRAM test, 2-7 reserved.
// - Test data register holds the byte written or read; resets to zero.
// - Diagnostic access targets the differential-delay SRAM, internal or external.
// - Link field bits 4-0 selects the PHY port reported by diagnostics.
// - Diagnostic select bit 5 is read-only, the write counter's top bit.
// - Snapshot holds 8 low counter bits captured when the read phase is zero.
// - Snapshot scaled: window 0 halves, windows 1-3 unchanged, window 4 quarters.
//
// Added by the designer: the APB interface to the registers.
`default_nettype none
module imacfg_regs #(
    parameter int GROUPS = 16,  // Number of IMA groups.
    parameter int CNT_W  = 11   // Width of the per-link SRAM write counter.
) (
    input  wire logic                       pclk,                   // APB clock, 25 MHz.
    input  wire logic                       presetn,                // Asynchronous reset, active low.
    input  wire logic                       psel,                   // APB select.
    input  wire logic                       penable,                // APB access phase.
    input  wire logic                       pwrite,                 // APB direction, high for write.
    input  wire logic [15:0]                paddr,                  // APB byte address.
    input  wire logic [31:0]                pwdata,                 // APB write data.
    output logic [31:0]                     prdata,                 // APB read data.
    output logic                            pready,                 // APB ready.
    output logic                            pslverr,                // APB error for unmapped address.
    input  wire logic [GROUPS-1:0]          group_state_machine_down, // Group state machine is down.
    input  wire logic [GROUPS-1:0]          group_cell_avail,       // Normal tx cell-available.
    input  wire logic [GROUPS-1:0]          group_cell_avail_all,   // Cell-available if all links active.
    output logic [GROUPS-1:0]               atm_tx_cell_available,  // Per-group tx cell-available.
    input  wire logic [4:0]                 phy_address,            // Current PHY-side address.
    output logic [4:0]                      phy_share_index,        // Shared cell-available/enable set.
    input  wire logic                       hec_valid,              // Header-check byte present.
    input  wire logic [7:0]                 hec_byte,               // Received header-check byte.
    input  wire logic                       hec_internal_error,     // Internal verifier result.
    output logic                            hec_error,              // Selected header error flag.
    input  wire logic [4:0]                 atm_tx_address,         // Tx ATM-side address bus.
    input  wire logic [4:0]                 atm_tx_expected,        // Tx address to match.
    input  wire logic [4:0]                 atm_rx_address,         // Rx ATM-side address bus.
    input  wire logic [4:0]                 atm_rx_expected,        // Rx address to match.
    output logic                            atm_tx_addr_match,      // Tx address matches.
    output logic                            atm_rx_addr_match,      // Rx address matches.
    output logic                            sram_test_active,       // SRAM held for test access.
    output imacfg_pkg::imacfg_sram_req_s    sram_out,               // Test request to the SRAM.
    input  wire logic                       sram_ack,               // SRAM access complete.
    input  wire logic [7:0]                 sram_rdata,             // SRAM read byte.
    output logic [4:0]                      diag_link,              // Selected diagnostic port.
    input  wire logic [CNT_W-1:0]           diag_write_counter,     // Write counter of that port.
    input  wire logic                       diag_read_phase_zero,   // Pulse when the read phase is zero.
    input  wire logic [2:0]                 delay_window            // Delay window setting.
);

    // ========================================================
    // Decoding helpers.
    // ========================================================
    // Register index from the byte address.
    function automatic logic [11:0] reg_index(input logic [15:0] a);
        return a[13:2];
    endfunction

    // True for an address that names a register of this set.
    function automatic logic is_mapped(input logic [15:0] a);
        logic [11:0] i;
        i = reg_index(a);
        return (a[15:14] == 2'h0) && (a[1:0] == 2'h0) &&
               (i >= imacfg_pkg::IDX_MISC_CONTROL) && (i <= imacfg_pkg::IDX_LINK_DELAY_SNAP);
    endfunction

    // Index of the shared PHY-side signal set for an address.
    function automatic logic [4:0] share_index(input logic [1:0] mode, input logic [4:0] a);
        logic [4:0] r;
        r = 5'h00;
        unique case (mode)
            imacfg_pkg::PHY_PER_4:  r = {2'h0, a[4:2]};
            imacfg_pkg::PHY_PER_16: r = {4'h0, a[4]};
            imacfg_pkg::PHY_SHARED: r = 5'h00;
            imacfg_pkg::PHY_PER_8:  r = {3'h0, a[4:3]};
        endcase
        return r;
    endfunction

    // Address compare; bits 4-2 only where the check bit is set.
    function automatic logic addr_match(input logic [4:0] a, input logic [4:0] e, input logic [2:0] chk);
        logic [4:0] m;
        m = {chk, 2'h3};
        return ((a ^ e) & m) == 5'h00;
    endfunction

    // Write counter scaled by the delay window.
    function automatic logic [8:0] scale_count(input logic [CNT_W-1:0] c, input logic [2:0] w);
        logic [CNT_W-1:0] s;
        s = c;
        if (w == imacfg_pkg::WIN_HALF) begin
            s = c >> 1;
        end else if (w == imacfg_pkg::WIN_QUARTER) begin
            s = c >> 2;
        end
        return s[8:0];
    endfunction

    // ========================================================
    // Register state.
    // ========================================================
    logic [7:0]  misc_control_r;
    logic [7:0]  mem_test_addr_low_r;
    logic [7:0]  mem_test_addr_mid_r;
    logic [7:0]  mem_test_control_r;
    logic [7:0]  mem_test_data_r;
    logic [7:0]  link_diag_select_r;
    logic [8:0]  snapshot_r;
    logic        busy_r;

    logic [11:0] idx;
    logic        access;
    logic        commit;
    logic        sram_mode;
    logic        sram_op;
    logic        start;
    logic        eng_done;
    logic [7:0]  eng_rdata;
    logic [20:0] test_addr;
    logic [7:0]  rd_byte;

    // Bus phase decode.
    assign idx       = reg_index(paddr);
    assign access    = psel && penable;
    assign commit    = access && pready;
    assign sram_mode = mem_test_control_r[imacfg_pkg::TCTL_MODE_LSB +: 3] == imacfg_pkg::TEST_SRAM;
    assign sram_op   = sram_mode && is_mapped(paddr) && (idx == imacfg_pkg::IDX_MEM_TEST_DATA);
    assign start     = access && sram_op && !busy_r && !pready;

    // The test address is assembled from four register fields.
    assign test_addr = {mem_test_control_r[imacfg_pkg::TCTL_ADDR20_BIT],
                        mem_test_control_r[imacfg_pkg::TCTL_ADDR_HI_LSB +: 4],
                        mem_test_addr_mid_r,
                        mem_test_addr_low_r};

    // ========================================================
    // SRAM test access engine.
    // ========================================================
    // Drives the differential-delay SRAM port, internal or external.
    imacfg_sram_tester u_tester (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (start),
        .we         (pwrite),
        .addr       (test_addr),
        .wdata      (pwdata[7:0]),
        .sram_out   (sram_out),
        .sram_ack   (sram_ack),
        .sram_rdata (sram_rdata),
        .done       (eng_done),
        .rdata      (eng_rdata)
    );

    // ========================================================
    // APB answer.
    // ========================================================
    // Read multiplexer over all registers.
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            imacfg_pkg::IDX_MISC_CONTROL:     rd_byte = misc_control_r;
            imacfg_pkg::IDX_MEM_TEST_ADDR_LO: rd_byte = mem_test_addr_low_r;
            imacfg_pkg::IDX_MEM_TEST_ADDR_MI: rd_byte = mem_test_addr_mid_r;
            imacfg_pkg::IDX_MEM_TEST_CONTROL: rd_byte = mem_test_control_r;
            imacfg_pkg::IDX_MEM_TEST_DATA:    rd_byte = sram_op ? eng_rdata : mem_test_data_r;
            imacfg_pkg::IDX_LINK_DIAG_SELECT: begin
                rd_byte = link_diag_select_r;
                rd_byte[imacfg_pkg::DIAG_WCNT_MSB_BIT] = snapshot_r[8];
            end
            imacfg_pkg::IDX_LINK_DELAY_SNAP:  rd_byte = snapshot_r[7:0];
            default:                          rd_byte = 8'h00;
        endcase
    end

    // Ready one cycle into the access phase, or after the SRAM completes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (pready) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (access && (sram_op ? eng_done : 1'b1)) begin
            pready  <= 1'b1;
            pslverr <= !is_mapped(paddr);
            prdata  <= (pwrite || !is_mapped(paddr)) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
    end

    // Marks an SRAM access in flight so it is launched once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
        end else if (start) begin
            busy_r <= 1'b1;
        end else if (eng_done) begin
            busy_r <= 1'b0;
        end
    end

    // ========================================================
    // Register writes, taken at the completing edge.
    // ========================================================
    // Configuration and address registers; reserved bits stay zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc_control_r      <= imacfg_pkg::RST_MISC_CONTROL;
            mem_test_addr_low_r <= imacfg_pkg::RST_ADDR_BYTE;
            mem_test_addr_mid_r <= imacfg_pkg::RST_ADDR_BYTE;
            mem_test_control_r  <= imacfg_pkg::RST_TEST_CONTROL;
            link_diag_select_r  <= imacfg_pkg::RST_DIAG_SELECT;
        end else if (commit && pwrite && !pslverr) begin
            unique case (idx)
                imacfg_pkg::IDX_MISC_CONTROL:
                    misc_control_r <= pwdata[7:0] & imacfg_pkg::MISC_WRITE_MASK;
                imacfg_pkg::IDX_MEM_TEST_ADDR_LO:
                    mem_test_addr_low_r <= pwdata[7:0];
                imacfg_pkg::IDX_MEM_TEST_ADDR_MI:
                    mem_test_addr_mid_r <= pwdata[7:0];
                imacfg_pkg::IDX_MEM_TEST_CONTROL:
                    mem_test_control_r <= pwdata[7:0];
                imacfg_pkg::IDX_LINK_DIAG_SELECT:
                    link_diag_select_r <= pwdata[7:0] & imacfg_pkg::DIAG_WRITE_MASK;
                default: ;
            endcase
        end
    end

    // Test data register: host byte on write, SRAM byte after a test read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_test_data_r <= imacfg_pkg::RST_TEST_DATA;
        end else if (commit && !pslverr && idx == imacfg_pkg::IDX_MEM_TEST_DATA) begin
            if (pwrite) begin
                mem_test_data_r <= pwdata[7:0];
            end else if (sram_op) begin
                mem_test_data_r <= eng_rdata;
            end
        end
    end

    // ========================================================
    // Differential delay snapshot.
    // ========================================================
    // Captures the scaled write counter when the read phase is zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snapshot_r <= imacfg_pkg::RST_SNAPSHOT;
        end else if (diag_read_phase_zero) begin
            snapshot_r <= scale_count(diag_write_counter, delay_window);
        end
    end

    // Port selection for the delay and anomaly datapath.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag_link <= 5'h00;
        end else begin
            diag_link <= link_diag_select_r[imacfg_pkg::DIAG_LINK_LSB +: 5];
        end
    end

    // ========================================================
    // Datapath controls.
    // ========================================================
    // Per-group tx cell-available: normal flag while up; while the group is down, the all-active flag if bit 6 is set, else zero.
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                atm_tx_cell_available[g] <= 1'b0;
            end else if (group_state_machine_down[g]) begin
                atm_tx_cell_available[g] <= misc_control_r[imacfg_pkg::MISC_ALT_GROUP_BIT] &&
                                            group_cell_avail_all[g];
            end else begin
                atm_tx_cell_available[g] <= group_cell_avail[g];
            end
        end
    end

    // PHY-side sharing of cell-available and enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_share_index <= 5'h00;
        end else begin
            phy_share_index <= share_index(misc_control_r[imacfg_pkg::MISC_PHY_SIZE_LSB +: 2],
                                           phy_address);
        end
    end

    // Header-check error source selection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hec_error <= 1'b0;
        end else if (!hec_valid) begin
            hec_error <= 1'b0;
        end else if (misc_control_r[imacfg_pkg::MISC_EXT_HEC_BIT]) begin
            hec_error <= hec_byte[7];
        end else begin
            hec_error <= hec_internal_error;
        end
    end

    // ATM-side address comparison on both buses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            atm_tx_addr_match <= 1'b0;
            atm_rx_addr_match <= 1'b0;
        end else begin
            atm_tx_addr_match <= addr_match(atm_tx_address, atm_tx_expected,
                                            misc_control_r[imacfg_pkg::MISC_ADDR_CHK_LSB +: 3]);
            atm_rx_addr_match <= addr_match(atm_rx_address, atm_rx_expected,
                                            misc_control_r[imacfg_pkg::MISC_ADDR_CHK_LSB +: 3]);
        end
    end

    // Test ownership of the SRAM, normal operation otherwise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sram_test_active <= 1'b0;
        end else begin
            sram_test_active <= sram_mode;
        end
    end

endmodule
`default_nettype wire

// file: dv/imacfg_props.sv
`default_nettype none
// ============================================================
// Port checks of the configuration and diagnostic registers.
module imacfg_props #(parameter int GROUPS = 16) (
    input wire logic pclk, presetn, pready, hec_valid, hec_error, sram_ack, sram_test_active, // Scalars.
    input wire logic [31:0] prdata, // Read data.
    input wire logic [GROUPS-1:0] group_state_machine_down, group_cell_avail, group_cell_avail_all, // Groups.
    input wire logic [GROUPS-1:0] atm_tx_cell_available, // Group outputs.
    input wire logic [4:0] atm_tx_address, atm_tx_expected, // Tx address pair.
    input wire logic atm_tx_addr_match, // Tx match.
    input wire imacfg_pkg::imacfg_sram_req_s sram_out // Test request.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Up groups follow their normal flag; down groups never show more than the all-active flag.
    AST_TX_CAV_UP: assert property ($past(presetn) |->
        ((atm_tx_cell_available ^ $past(group_cell_avail)) & ~$past(group_state_machine_down)) == '0)
        else $error("tx cell-available wrong for an up group");
    AST_TX_CAV_DOWN: assert property ((atm_tx_cell_available & $past(group_state_machine_down)
        & ~$past(group_cell_avail_all)) == '0) else $error("tx cell-available set for a down group");
    AST_HEC_IDLE: assert property (!hec_valid |=> !hec_error) else $error("header error without a byte");
    AST_TX_LOW_BITS: assert property (atm_tx_address[1:0] != atm_tx_expected[1:0] |=>
        !atm_tx_addr_match) else $error("tx match despite differing low address bits");
    AST_SRAM_MODE: assert property (sram_out.req |-> sram_test_active) else $error("request outside test");
    AST_SRAM_HOLD: assert property (sram_out.req && !sram_ack |=> sram_out.req && $stable(sram_out))
        else $error("test request changed before its acknowledge");
    AST_SRAM_DONE: assert property (sram_out.req && sram_ack |=> !sram_out.req ##1 pready)
        else $error("test access did not finish after acknowledge");
    AST_BYTE_DATA: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper data bits set");
    cover property (sram_out.req && sram_ack);
    cover property (hec_error);
    cover property (atm_tx_addr_match);
endmodule
bind imacfg_regs imacfg_props #(.GROUPS(GROUPS)) u_props (.*);
`default_nettype wire

// file: dv/tb_top.sv
`default_nettype none
// ============================================================
// Self-checking bench of the configuration register set.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sram_ack, sram_test_active, er;
    logic hec_valid, hec_internal_error, hec_error, atm_tx_addr_match, atm_rx_addr_match, diag_read_phase_zero;
    logic [15:0] paddr, group_state_machine_down, group_cell_avail, group_cell_avail_all, atm_tx_cell_available;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] hec_byte, sram_rdata, mem, m;
    logic [4:0] phy_address, phy_share_index, atm_tx_address, atm_tx_expected, atm_rx_address, atm_rx_expected;
    logic [4:0] diag_link;
    logic [10:0] diag_write_counter, s;
    logic [2:0] delay_window;
    imacfg_pkg::imacfg_sram_req_s sram_out, seen;
    int err_count, checks;
    localparam logic [15:0] ROWS [7] = '{16'h7F7F, 16'hA5A5, 16'h5A5A, 16'h8F8F, 16'h3C3C, 16'h3F1F, 16'h7700};
    localparam logic [7:0] MISC [4] = '{8'h4D, 8'h12, 8'h6E, 8'h31};
    localparam logic [2:0] WIN [3] = '{3'h0, 3'h2, 3'h4};
    imacfg_regs dut (.*);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // SRAM stand-in: acknowledges one cycle after a request and keeps one byte.
    always @(posedge pclk) begin
        sram_ack <= sram_out.req && !sram_ack;
        if (sram_out.req && !sram_ack) seen <= sram_out;
        if (sram_out.req && sram_out.we && !sram_ack) mem <= sram_out.wdata;
        sram_rdata <= sram_ack ? ~mem : mem;
    end
    function automatic logic [15:0] ra(input int i);
        return {2'b00, imacfg_pkg::IDX_MISC_CONTROL + 12'(i), 2'b00};
    endfunction
    // One APB transfer; the request stands until the rising edge at which pready is sampled high.
    task automatic apb(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h00_0000, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Watchdog.
    initial begin
        #100us;
        err_count++;
        stop_test();
    end
    // Main sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, diag_read_phase_zero} = '0;
        {hec_valid, hec_byte, hec_internal_error, delay_window, presetn} = {1'b0, 8'h80, 1'b0, 3'h0, 1'b0};
        {group_state_machine_down, group_cell_avail, group_cell_avail_all} = {16'hFF00, 16'h00FF, 16'hA5A5};
        {phy_address, atm_tx_address, atm_tx_expected} = {5'h1D, 5'h14, 5'h07};
        {atm_rx_address, atm_rx_expected, diag_write_counter} = {5'h08, 5'h00, 11'h5A7};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(ra(i), 1'b0, 8'h00);
            chk(rd, 32'h0000_0000);
            apb(ra(i), 1'b1, ROWS[i][15:8]);
            apb(ra(i), 1'b0, 8'h00);
            chk(rd, {24'h00_0000, ROWS[i][7:0]});
        end
        apb(16'h1011, 1'b1, 8'h00);
        chk(er, 1'b1);
        {hec_valid, atm_tx_expected} <= {1'b1, 5'h00};
        foreach (MISC[j]) begin
            m = MISC[j];
            apb(ra(0), 1'b1, m);
            repeat (2) @(negedge pclk);
            chk(atm_tx_cell_available, m[6] ? 16'hA5FF : 16'h00FF);
            chk(phy_share_index, m[5] ? (m[4] ? 5'h03 : 5'h00) : (m[4] ? 5'h01 : 5'h07));
            chk(hec_error, m[3]);
            chk({atm_tx_addr_match, atm_rx_addr_match}, {!(m[2] || m[0]), !m[1]});
        end
        apb(ra(3), 1'b1, 8'h96);
        repeat (2) @(negedge pclk);
        chk(sram_test_active, 1'b1);
        apb(ra(4), 1'b1, 8'hC3);
        chk(seen, {2'b11, 21'h16_5AA5, 8'hC3});
        apb(ra(4), 1'b0, 8'h00);
        chk(rd, 32'h0000_00C3);
        chk(seen.we, 1'b0);
        apb(ra(3), 1'b1, 8'hA6);
        repeat (2) @(negedge pclk);
        chk(sram_test_active, 1'b0);
        foreach (WIN[j]) begin
            @(posedge pclk) {delay_window, diag_read_phase_zero} <= {WIN[j], 1'b1};
            @(posedge pclk) diag_read_phase_zero <= 1'b0;
            s = (WIN[j] == 3'h0) ? 11'h5A7 >> 1 : (WIN[j] == 3'h4) ? 11'h5A7 >> 2 : 11'h5A7;
            apb(ra(6), 1'b0, 8'h00);
            chk(rd, {24'h00_0000, s[7:0]});
            apb(ra(5), 1'b0, 8'h00);
            chk(rd, {26'h000_0000, s[8], 5'h1F});
        end
        chk(diag_link, 5'h1F);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(ra(4), 1'b0, 8'h00);
        chk(rd, 32'h0000_0000);
        stop_test();
    end
endmodule
`default_nettype wire
